// [inc/cad_params.svh]
// Constants for the descriptor parser and scramble detector.
// Assumes inclusion by bare name from the package and the design.
`ifndef CAD_PARAMS_SVH
`define CAD_PARAMS_SVH
// Register byte offsets on the APB bus.
`define CAD_OFF_CTRL 12'h000
`define CAD_OFF_STATUS 12'h004
`define CAD_OFF_MASK 12'h008
`define CAD_OFF_CONTRACT 12'h00C
`define CAD_OFF_FEE 12'h010
`define CAD_OFF_SERVICE 12'h014
`define CAD_OFF_MSG 12'h018
`define CAD_OFF_DATE 12'h01C
`define CAD_OFF_PID_BASE 12'h040
`define CAD_OFF_KEY_BASE 12'h080
// Table sizes.
`define CAD_NUM_PID 12
`define CAD_NUM_KEYW 16
// Descriptor tags, plain defaults.
`define CAD_CON_TAG 8'hCB
`define CAD_SVC_TAG 8'hCC
// Field values.
`define CAD_UNIT_NONBILL 4'h0
`define CAD_UNIT_DEFAULT 4'h1
`define CAD_DELAY_HOLD 8'hFF
// Status bit positions.
`define CAD_EV_CONTRACT 0
`define CAD_EV_MALFORMED 1
`define CAD_EV_LENERR 2
`define CAD_EV_SERVICE 3
`define CAD_EV_VERDICT 4
`define CAD_EV_UNDEF 5
`define CAD_EV_W 6
// Control bit positions and reset value.
`define CAD_CTRL_EN 0
`define CAD_CTRL_PLAY 1
`define CAD_CTRL_NEWEV 2
`define CAD_CTRL_RST 3'h1
`endif

// [inc/cad_pkg.sv]
// Types shared by the descriptor parser and scramble detector.
// Assumes cad_params.svh is on the include path.
package cad_pkg;
  `include "cad_params.svh"
  typedef enum logic [1:0] {TBL_SDT, TBL_EIT, TBL_CAT} cad_tbl_t;
  typedef enum logic [1:0] {SC_CLEAR, SC_EVEN, SC_ODD, SC_UNDEF} cad_class_t;
  typedef enum logic [3:0] {PS_IDLE, PS_LEN, PS_SYS_H, PS_SYS_L, PS_UNIT, PS_COMP, PS_VLEN, PS_VBYTE,
    PS_FLEN, PS_FBYTE, PS_GROUP, PS_DELAY, PS_SVC_H, PS_SVC_L, PS_DROP} cad_pstate_t;
  typedef struct packed {
    logic vld;
    logic first;
    cad_tbl_t tbl;
    logic [7:0] data;
  } cad_desc_in_t;
  typedef struct packed {
    logic vld;
    logic [12:0] pid;
    logic [1:0] scr;
    logic [1:0] afc;
  } cad_ts_in_t;
  typedef struct packed {
    logic vld;
    logic ok;
  } cad_verdict_t;
  typedef struct packed {
    logic vld;
    logic [7:0] data;
    logic done;
    logic [15:0] date;
  } cad_card_out_t;
  typedef struct packed {
    logic vld;
    logic hit;
    cad_class_t cls;
    logic [12:0] pid;
    logic [31:0] key;
  } cad_pkt_out_t;
endpackage

// [hdl/cad_core.sv]
// Descriptor parser for contract and access-service descriptors, plus
// per-packet scramble classification with PID and key tables, on APB.
// Assumes a byte stream from the section filter and TS headers on pclk.
//
// Summary of operation
// - Parse tag, length, system, unit, count.
// - Read component tags, then verification bytes.
// - Unit one default group, two-fifteen others.
// - Unit zero flagged as malformed.
// - Read fee name length and bytes.
// - Service table: send bytes, date; take verdict.
// - Event table: classify flat or pay-per-view.
// - Parse service descriptor from access table.
// - Delay days, 255 means held.
// - Playback suppresses message when delay LSB set.
// - Classify each packet from both header fields.
// - Clear, even key, odd key decoding.
// - Other combinations are undefined.
// - Hold eight even and odd key pairs.
// - Handle twelve PIDs concurrently.
// - Event table copy overrides service table.
`timescale 1ns/100ps
`include "cad_params.svh"
module cad_core
  import cad_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cad_desc_in_t desc_in,
  input wire cad_ts_in_t ts_in,
  input wire cad_verdict_t verdict_in,
  output cad_card_out_t card_out,
  output cad_pkt_out_t pkt_out,
  output logic msg_suppress,
  output logic irq
);
  // ****************************************
  // Registers and decode
  // ****************************************
  logic [2:0] ctrl_reg;
  logic [`CAD_EV_W-1:0] status_reg, mask_reg, ev_next;
  logic [15:0] date_reg;
  logic [13:0] pid_reg [0:`CAD_NUM_PID-1];
  logic [2:0] slot_reg [0:`CAD_NUM_PID-1];
  logic [31:0] key_reg [0:`CAD_NUM_KEYW-1];
  logic [15:0] con_sys_reg, srv_sys_reg;
  logic [3:0] con_unit_reg, con_ncomp_reg;
  logic con_ppv_reg, con_ok_reg, eit_held_reg;
  logic [31:0] con_fee_reg;
  logic [7:0] srv_group_reg, srv_delay_reg, srv_count_reg;
  logic wr, rd_setup;
  logic [31:0] rd_val;

  function automatic logic in_win(input logic [11:0] a, input logic [11:0] base, input int n);
    in_win = (a >= base) && (a < base + 12'(4 * n));
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  // Zero wait states; the read word is captured in the setup cycle.
  assign pready = 1'b1;

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (1'b1)
      paddr == `CAD_OFF_CTRL: rd_val = {29'h0, ctrl_reg};
      paddr == `CAD_OFF_STATUS: rd_val = {26'h0, status_reg};
      paddr == `CAD_OFF_MASK: rd_val = {26'h0, mask_reg};
      paddr == `CAD_OFF_CONTRACT: rd_val = {con_sys_reg, con_unit_reg, con_ncomp_reg, 4'h0,
        con_unit_reg == `CAD_UNIT_DEFAULT, eit_held_reg, con_ok_reg, con_ppv_reg};
      paddr == `CAD_OFF_FEE: rd_val = con_fee_reg;
      paddr == `CAD_OFF_SERVICE: rd_val = {srv_sys_reg, srv_group_reg, srv_delay_reg};
      paddr == `CAD_OFF_MSG:
        rd_val = {14'h0, msg_suppress, srv_delay_reg == `CAD_DELAY_HOLD, srv_count_reg, srv_delay_reg};
      paddr == `CAD_OFF_DATE: rd_val = {16'h0, date_reg};
      in_win(paddr, `CAD_OFF_PID_BASE, `CAD_NUM_PID):
        rd_val = {15'h0, slot_reg[paddr[5:2]], pid_reg[paddr[5:2]]};
      in_win(paddr, `CAD_OFF_KEY_BASE, `CAD_NUM_KEYW): rd_val = key_reg[paddr[5:2]];
      default: rd_val = 32'h0000_0000;
    endcase
  end

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'h0) && ((a <= `CAD_OFF_DATE) || in_win(a, `CAD_OFF_PID_BASE, `CAD_NUM_PID)
      || in_win(a, `CAD_OFF_KEY_BASE, `CAD_NUM_KEYW));
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= !mapped(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CAD_CTRL_RST;
      mask_reg <= '0;
      date_reg <= 16'h0000;
    end else if (wr) begin
      if (paddr == `CAD_OFF_CTRL) ctrl_reg <= pwdata[2:0];
      if (paddr == `CAD_OFF_MASK) mask_reg <= pwdata[`CAD_EV_W-1:0];
      if (paddr == `CAD_OFF_DATE) date_reg <= pwdata[15:0];
    end else begin
      ctrl_reg[`CAD_CTRL_NEWEV] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `CAD_NUM_PID; i++) begin
        pid_reg[i] <= 14'h0000;
        slot_reg[i] <= 3'h0;
      end
      for (int i = 0; i < `CAD_NUM_KEYW; i++) begin
        key_reg[i] <= 32'h0000_0000;
      end
    end else if (wr && in_win(paddr, `CAD_OFF_PID_BASE, `CAD_NUM_PID)) begin
      pid_reg[paddr[5:2]] <= pwdata[13:0];
      slot_reg[paddr[5:2]] <= pwdata[16:14];
    end else if (wr && in_win(paddr, `CAD_OFF_KEY_BASE, `CAD_NUM_KEYW)) begin
      key_reg[paddr[5:2]] <= pwdata;
    end
  end

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~((wr && paddr == `CAD_OFF_STATUS) ? pwdata[`CAD_EV_W-1:0] : '0)) | ev_next;
    end
  end
  assign irq = |(status_reg & mask_reg);

  // ****************************************
  // Descriptor parser
  // ****************************************
  cad_pstate_t st_reg;
  cad_tbl_t tbl_reg;
  logic [7:0] rem_reg, cnt_reg, rem_after, w_group, w_delay, w_count;
  logic [15:0] w_sys;
  logic [3:0] w_unit, w_ncomp;
  logic [31:0] w_fee;
  logic w_ppv, con_done, srv_done, len_err, malformed, dv, tag_ok;

  assign dv = desc_in.vld && ctrl_reg[`CAD_CTRL_EN];
  assign rem_after = rem_reg - 8'h01;
  assign tag_ok = (desc_in.tbl == TBL_CAT) ? (desc_in.data == `CAD_SVC_TAG) : (desc_in.data == `CAD_CON_TAG);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= PS_IDLE;
      tbl_reg <= TBL_SDT;
      rem_reg <= 8'h00;
      cnt_reg <= 8'h00;
      w_sys <= 16'h0000;
      w_unit <= 4'h0;
      w_ncomp <= 4'h0;
      w_fee <= 32'h0000_0000;
      w_ppv <= 1'b0;
      w_group <= 8'h00;
      w_delay <= 8'h00;
      w_count <= 8'h00;
      con_done <= 1'b0;
      srv_done <= 1'b0;
      len_err <= 1'b0;
      malformed <= 1'b0;
      card_out <= '0;
    end else begin
      con_done <= 1'b0;
      srv_done <= 1'b0;
      len_err <= 1'b0;
      malformed <= 1'b0;
      card_out.vld <= 1'b0;
      card_out.done <= 1'b0;
      if (dv && desc_in.first) begin
        tbl_reg <= desc_in.tbl;
        st_reg <= tag_ok ? PS_LEN : PS_IDLE;
      end else if (dv && st_reg != PS_IDLE && st_reg != PS_DROP) begin
        if (st_reg != PS_LEN && rem_reg == 8'h00) begin
          st_reg <= PS_DROP;
          len_err <= 1'b1;
        end else begin
          if (st_reg != PS_LEN) rem_reg <= rem_after;
          unique case (st_reg)
            PS_LEN: begin
              rem_reg <= desc_in.data;
              st_reg <= PS_SYS_H;
            end
            PS_SYS_H: begin
              w_sys[15:8] <= desc_in.data;
              st_reg <= PS_SYS_L;
            end
            PS_SYS_L: begin
              w_sys[7:0] <= desc_in.data;
              st_reg <= (tbl_reg == TBL_CAT) ? PS_GROUP : PS_UNIT;
            end
            PS_UNIT: begin
              w_unit <= desc_in.data[7:4];
              w_ncomp <= desc_in.data[3:0];
              cnt_reg <= {4'h0, desc_in.data[3:0]};
              malformed <= desc_in.data[7:4] == `CAD_UNIT_NONBILL;
              st_reg <= (desc_in.data[3:0] == 4'h0) ? PS_VLEN : PS_COMP;
            end
            PS_COMP: begin
              cnt_reg <= cnt_reg - 8'h01;
              if (cnt_reg == 8'h01) st_reg <= PS_VLEN;
            end
            PS_VLEN: begin
              if (desc_in.data > rem_after) begin
                st_reg <= PS_DROP;
                len_err <= 1'b1;
              end else begin
                cnt_reg <= desc_in.data;
                w_ppv <= (tbl_reg == TBL_EIT) && (desc_in.data != 8'h00);
                card_out.done <= desc_in.data == 8'h00;
                card_out.date <= date_reg;
                st_reg <= (desc_in.data == 8'h00) ? PS_FLEN : PS_VBYTE;
              end
            end
            PS_VBYTE: begin
              card_out.vld <= 1'b1;
              card_out.data <= desc_in.data;
              cnt_reg <= cnt_reg - 8'h01;
              if (cnt_reg == 8'h01) begin
                card_out.done <= 1'b1;
                card_out.date <= date_reg;
                st_reg <= PS_FLEN;
              end
            end
            PS_FLEN: begin
              if (desc_in.data > rem_after) begin
                st_reg <= PS_DROP;
                len_err <= 1'b1;
              end else begin
                cnt_reg <= desc_in.data;
                w_fee <= 32'h0000_0000;
                con_done <= desc_in.data == 8'h00;
                st_reg <= (desc_in.data == 8'h00) ? PS_IDLE : PS_FBYTE;
              end
            end
            // Only the last four fee name bytes are kept for software.
            PS_FBYTE: begin
              w_fee <= {w_fee[23:0], desc_in.data};
              cnt_reg <= cnt_reg - 8'h01;
              if (cnt_reg == 8'h01) begin
                con_done <= 1'b1;
                st_reg <= PS_IDLE;
              end
            end
            PS_GROUP: begin
              w_group <= desc_in.data;
              st_reg <= PS_DELAY;
            end
            PS_DELAY: begin
              w_delay <= desc_in.data;
              w_count <= {1'b0, rem_after[7:1]};
              srv_done <= rem_after == 8'h00;
              st_reg <= (rem_after == 8'h00) ? PS_IDLE : PS_SVC_H;
            end
            // An odd trailing byte is dropped without error.
            PS_SVC_H: begin
              srv_done <= rem_after == 8'h00;
              st_reg <= (rem_after == 8'h00) ? PS_IDLE : PS_SVC_L;
            end
            PS_SVC_L: begin
              srv_done <= rem_after == 8'h00;
              st_reg <= (rem_after == 8'h00) ? PS_IDLE : PS_SVC_H;
            end
            default: st_reg <= PS_IDLE;
          endcase
        end
      end
    end
  end

  // ****************************************
  // Committed results and card verdict
  // ****************************************
  logic con_take;
  assign con_take = con_done && (tbl_reg == TBL_EIT || !eit_held_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      con_sys_reg <= 16'h0000;
      con_unit_reg <= 4'h0;
      con_ncomp_reg <= 4'h0;
      con_fee_reg <= 32'h0000_0000;
      con_ppv_reg <= 1'b0;
      eit_held_reg <= 1'b0;
      con_ok_reg <= 1'b0;
      srv_sys_reg <= 16'h0000;
      srv_group_reg <= 8'h00;
      srv_delay_reg <= 8'h00;
      srv_count_reg <= 8'h00;
      msg_suppress <= 1'b0;
    end else begin
      if (con_take) begin
        con_sys_reg <= w_sys;
        con_unit_reg <= w_unit;
        con_ncomp_reg <= w_ncomp;
        con_fee_reg <= w_fee;
        con_ppv_reg <= w_ppv;
      end
      if (con_take && tbl_reg == TBL_EIT) eit_held_reg <= 1'b1;
      else if (ctrl_reg[`CAD_CTRL_NEWEV]) eit_held_reg <= 1'b0;
      if (verdict_in.vld) con_ok_reg <= verdict_in.ok;
      if (srv_done) begin
        srv_sys_reg <= w_sys;
        srv_group_reg <= w_group;
        srv_delay_reg <= w_delay;
        srv_count_reg <= w_count;
      end
      msg_suppress <= ctrl_reg[`CAD_CTRL_PLAY] && srv_delay_reg[0];
    end
  end

  // ****************************************
  // Scramble detection
  // ****************************************
  // key selection
  function automatic cad_class_t classify(input logic [1:0] scr, input logic [1:0] afc);
    if (!afc[0] || scr == 2'h1) classify = SC_UNDEF;
    else if (scr == 2'h0) classify = SC_CLEAR;
    else if (scr == 2'h2) classify = SC_EVEN;
    else classify = SC_ODD;
  endfunction

  logic [`CAD_NUM_PID-1:0] hit;
  logic [2:0] hit_slot;
  logic [3:0] hit_key;
  cad_class_t ts_cls;

  genvar g;
  generate
    for (g = 0; g < `CAD_NUM_PID; g++) begin : g_pid
      assign hit[g] = pid_reg[g][13] && pid_reg[g][12:0] == ts_in.pid;
    end
  endgenerate

  always_comb begin
    hit_slot = 3'h0;
    for (int i = `CAD_NUM_PID - 1; i >= 0; i--) begin
      if (hit[i]) hit_slot = slot_reg[i];
    end
  end
  assign ts_cls = classify(ts_in.scr, ts_in.afc);
  assign hit_key = {hit_slot, ts_cls == SC_ODD};

  assign ev_next = {(ts_in.vld && ctrl_reg[`CAD_CTRL_EN] && ts_cls == SC_UNDEF), verdict_in.vld,
    srv_done, len_err, malformed, con_take};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_out <= '0;
    end else begin
      pkt_out.vld <= ts_in.vld && ctrl_reg[`CAD_CTRL_EN];
      pkt_out.hit <= |hit;
      pkt_out.cls <= ts_cls;
      pkt_out.pid <= ts_in.pid;
      pkt_out.key <= (|hit && (ts_cls == SC_EVEN || ts_cls == SC_ODD)) ? key_reg[hit_key] : 32'h0000_0000;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pkt_latency: assert property (ts_in.vld && ctrl_reg[0] |=> pkt_out.vld)
    else $error("packet result missing");
  a_clear_cls: assert property (ts_in.vld && ts_in.afc[0] && ts_in.scr == 2'h0 |=> pkt_out.cls == SC_CLEAR)
    else $error("clear packet misclassified");
  a_odd_key: assert property (ts_in.vld && ts_in.afc[0] && ts_in.scr == 2'h3 |=> pkt_out.cls == SC_ODD)
    else $error("odd key packet misclassified");
  a_undef_cls: assert property (ts_in.vld && (!ts_in.afc[0] || ts_in.scr == 2'h1) |=> pkt_out.cls == SC_UNDEF)
    else $error("undefined combination not flagged");
  a_unit_zero: assert property (dv && !desc_in.first && st_reg == PS_UNIT && rem_reg != 8'h00
    && desc_in.data[7:4] == 4'h0 |=> ##1 status_reg[`CAD_EV_MALFORMED])
    else $error("unit zero not flagged");
  a_len_overrun: assert property (dv && !desc_in.first && st_reg == PS_VLEN && rem_reg != 8'h00
    && desc_in.data > rem_after |=> st_reg == PS_DROP ##1 status_reg[`CAD_EV_LENERR])
    else $error("verification length overrun missed");
  a_eit_keep: assert property (con_done && tbl_reg == TBL_SDT && eit_held_reg |=> $stable(con_sys_reg))
    else $error("service table copy overrode event copy");
  a_svc_count: assert property (dv && !desc_in.first && st_reg == PS_DELAY && rem_reg != 8'h00
    |=> w_count == ($past(rem_after) >> 1))
    else $error("service count wrong");
  a_suppress: assert property (srv_done && ctrl_reg[1] && !wr && w_delay[0] |=> ##1 msg_suppress)
    else $error("playback message not suppressed");

  c_contract: cover property (con_take && tbl_reg == TBL_EIT);
  c_service: cover property (srv_done && w_count != 8'h00);
  c_card: cover property (card_out.vld ##1 card_out.done);
  c_even: cover property (pkt_out.vld && pkt_out.hit && pkt_out.cls == SC_EVEN);
endmodule

// [tb/cad_partner.sv]
// Access card model: watches the bytes handed to the card and answers
// each finished hand-over with a one-cycle verdict pulse.
// Assumes the card port structs of cad_pkg and a single pclk domain.
`timescale 1ns/100ps
module cad_partner
  import cad_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire cad_card_out_t card_out,
  input wire logic ok_cfg,
  output cad_verdict_t verdict_in,
  output logic [7:0] last_byte,
  output logic [15:0] last_date,
  output logic done_seen
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      verdict_in <= '{vld: 1'b0, ok: 1'b1};
      last_byte <= 8'h00;
      last_date <= 16'h0000;
      done_seen <= 1'b0;
    end else begin
      // The verdict bit carries a wrong value while not qualified.
      verdict_in <= '{vld: card_out.done, ok: card_out.done ? ok_cfg : ~ok_cfg};
      if (card_out.vld) begin
        last_byte <= card_out.data;
      end
      if (card_out.done) begin
        last_date <= card_out.date;
        done_seen <= 1'b1;
      end
    end
  end
endmodule

// [tb/test_ca_descriptor_and_scramble_detect.sv]
// Self-checking bench for the descriptor parser and scramble detector.
// Assumes cad_core with zero-wait APB and the card model cad_partner.
`timescale 1ns/100ps
`include "cad_params.svh"
module test_ca_descriptor_and_scramble_detect;
  import cad_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, msg_suppress, irq, ok_cfg, done_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] last_byte;
  logic [15:0] last_date;
  cad_desc_in_t desc_in;
  cad_ts_in_t ts_in;
  cad_verdict_t verdict_in;
  cad_card_out_t card_out;
  cad_pkt_out_t pkt_out;
  int miscompares = 0;
  int comparisons = 0;

  cad_core i_cad_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .desc_in(desc_in),
    .ts_in(ts_in), .verdict_in(verdict_in), .card_out(card_out), .pkt_out(pkt_out),
    .msg_suppress(msg_suppress), .irq(irq));
  cad_partner i_cad_partner (.pclk(pclk), .presetn(presetn), .card_out(card_out), .ok_cfg(ok_cfg),
    .verdict_in(verdict_in), .last_byte(last_byte), .last_date(last_date), .done_seen(done_seen));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic complete_run();
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the wait for pready is bounded.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    logic e;
    apb(1'b0, a, 32'h0, v, e);
  endtask

  task automatic send(input cad_tbl_t t, input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge pclk);
      desc_in <= '{vld: 1'b1, first: (i == 0), tbl: t, data: b[i]};
    end
    @(posedge pclk);
    desc_in <= '0;
    repeat (4) @(posedge pclk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic e;
    rd(`CAD_OFF_CTRL, r);
    check(r, 32'h1);
    apb(1'b0, 12'h020, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    wr(`CAD_OFF_DATE, 32'h1234);
  endtask

  task automatic t_contract();
    ok_cfg <= 1'b1;
    send(TBL_SDT, '{8'hCB, 8'h07, 8'h12, 8'h34, 8'h10, 8'h01, 8'h5A, 8'h01, 8'h77});
    check({8'h0, last_date, last_byte}, {8'h0, 16'h1234, 8'h5A});
    check({31'h0, done_seen}, 32'h1);
    rd(`CAD_OFF_CONTRACT, r);
    check(r, 32'h1234_100A);
    rd(`CAD_OFF_FEE, r);
    check({24'h0, r[7:0]}, 32'h77);
    rd(`CAD_OFF_STATUS, r);
    check(r, 32'h11);
    wr(`CAD_OFF_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    wr(`CAD_OFF_STATUS, 32'h11);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    ok_cfg <= 1'b0;
    send(TBL_EIT, '{8'hCB, 8'h09, 8'h0B, 8'hCD, 8'h22, 8'hA1, 8'hA2, 8'h02, 8'h01, 8'h02, 8'h00});
    rd(`CAD_OFF_CONTRACT, r);
    check(r, 32'h0BCD_2205);
    send(TBL_SDT, '{8'hCB, 8'h07, 8'h55, 8'h55, 8'h10, 8'h01, 8'h5A, 8'h01, 8'h77});
    rd(`CAD_OFF_CONTRACT, r);
    check({16'h0, r[31:16]}, 32'h0BCD);
    send(TBL_EIT, '{8'hCB, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00});
    send(TBL_EIT, '{8'hCB, 8'h04, 8'h00, 8'h01, 8'h10, 8'h05});
    rd(`CAD_OFF_STATUS, r);
    check({30'h0, r[2:1]}, 32'h3);
    wr(`CAD_OFF_CTRL, 32'h5);
  endtask

  task automatic t_service();
    send(TBL_CAT, '{8'hCC, 8'h09, 8'hAB, 8'hCD, 8'h21, 8'h03, 8'h01, 8'h01, 8'h02, 8'h02, 8'hEE});
    rd(`CAD_OFF_SERVICE, r);
    check(r, 32'hABCD_2103);
    rd(`CAD_OFF_MSG, r);
    check(r, 32'h0000_0203);
    wr(`CAD_OFF_CTRL, 32'h3);
    repeat (2) @(posedge pclk);
    check({31'h0, msg_suppress}, 32'h1);
    send(TBL_CAT, '{8'hCC, 8'h04, 8'hAB, 8'hCD, 8'h21, 8'hFF});
    rd(`CAD_OFF_MSG, r);
    check({30'h0, r[17:16]}, 32'h3);
    wr(`CAD_OFF_CTRL, 32'h1);
  endtask

  // Every header combination on one enabled PID, then an unknown PID.
  task automatic t_scramble();
    logic [1:0] c;
    wr(`CAD_OFF_PID_BASE + 12'h02C, 32'h0000_E100);
    wr(`CAD_OFF_KEY_BASE + 12'h018, 32'hEEEE_0006);
    wr(`CAD_OFF_KEY_BASE + 12'h01C, 32'h0DD0_0007);
    for (int k = 0; k < 17; k++) begin
      c = (k[0] == 1'b0 || k[3:2] == 2'b01) ? 2'd3 : (k[3:2] == 2'b00) ? 2'd0 : k[3:2] - 2'd1;
      @(posedge pclk);
      ts_in <= '{vld: 1'b1, pid: (k == 16) ? 13'h1FF : 13'h100, scr: k[3:2], afc: k[1:0]};
      @(posedge pclk);
      ts_in <= '0;
      #1;
      check({pkt_out.vld, pkt_out.hit, 28'h0, logic'(1'b0), logic'(1'b0)}, {1'b1, k < 16, 30'h0});
      check({19'h0, pkt_out.pid}, {19'h0, (k == 16) ? 13'h1FF : 13'h100});
      if (k < 16) begin
        check({30'h0, pkt_out.cls}, {30'h0, c});
        check(pkt_out.key, (c == 2'd1) ? 32'hEEEE_0006 : (c == 2'd2) ? 32'h0DD0_0007 : 32'h0);
      end
    end
    rd(`CAD_OFF_STATUS, r);
    check({31'h0, r[5]}, 32'h1);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    desc_in = '0;
    ts_in = '0;
    ok_cfg = 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_contract();
    t_service();
    t_scramble();
    complete_run();
  end
endmodule
